/* File: rtl/ugr_glyph_addr.sv */
// User glyph RAM addressing: pointer, text wrap and dot generation.
`timescale 1ns/10ps
`default_nettype none
module ugr_glyph_addr
    import ugr_pkg::*;
#(
    parameter int PAT_DEPTH = 128
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Host command port
    input wire logic cmd_valid_in,
    input wire ugr_op_t cmd_in,
    input wire logic [CODE_W-1:0] cmd_data_in,
    output logic [PTR_W-1:0] address_pointer_out,
    output logic [DOT_W-1:0] read_data_out,
    output logic read_valid_out,
    // Display scan port
    input wire logic [CODE_W-1:0] char_code_in,
    input wire logic [LINE_W-1:0] dot_line_in,
    input wire logic cursor_here_in,
    input wire logic [DOT_W-1:0] rom_dots_in,
    input wire logic [COL_W-1:0] scan_col_in,
    input wire logic [1:0] scan_row_in,
    output logic [DOT_W-1:0] columns_out,
    output logic pattern_sel_out,
    output logic [PTR_W-1:0] text_addr_out
);
    typedef struct packed {
        logic [PTR_W-1:0] ptr;
        logic to_pattern;
        logic entry_up;
        logic mux_sel;
        logic line_cnt;
        logic [PTR_W-1:0] shift;
        logic rd_pend;
        logic rd_valid;
        logic [DOT_W-1:0] rd_data;
        logic s1_pat;
        logic s1_cursor_line;
        logic [DOT_W-1:0] s1_rom;
        logic [DOT_W-1:0] cols;
        logic pat_sel;
        logic [PTR_W-1:0] text_addr;
    } ugr_state_t;

    ugr_state_t st_r;
    ugr_state_t st_nxt;
    ugr_pat_if pat ();

    // ------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------
    function automatic ugr_mode_t mode_of(input logic m, input logic n);
        if (m && n) begin
            mode_of = MODE_FOUR;
        end else if (n) begin
            mode_of = MODE_TWO;
        end else begin
            mode_of = MODE_SPLIT;
        end
    endfunction

    function automatic logic [PTR_W-1:0] period_of(input ugr_mode_t md);
        case (md)
            MODE_TWO: period_of = TWO_LINE_LAST + 7'h01;
            MODE_FOUR: period_of = FOUR_LINE_LAST + 7'h01;
            default: period_of = SPLIT_HALF_LEN;
        endcase
    endfunction

    function automatic logic [PTR_W-1:0] step_text(input logic [PTR_W-1:0] p,
        input logic up, input ugr_mode_t md);
        logic [PTR_W-1:0] base;
        logic [PTR_W-1:0] last;
        base = '0;
        last = '0;
        case (md)
            MODE_TWO: begin
                base = p & TWO_LINE_BASE2;
                last = base + TWO_LINE_LAST;
                if (up) begin
                    step_text = (p == last) ? (base ^ TWO_LINE_BASE2) : p + 7'h01;
                end else begin
                    step_text = (p == base) ? ((base ^ TWO_LINE_BASE2) + TWO_LINE_LAST)
                        : p - 7'h01;
                end
            end
            MODE_FOUR: begin
                base = p & 7'h60;
                last = base + FOUR_LINE_LAST;
                if (up) begin
                    step_text = (p == last) ? base + FOUR_LINE_STEP : p + 7'h01;
                end else begin
                    step_text = (p == base) ? base - FOUR_LINE_STEP + FOUR_LINE_LAST
                        : p - 7'h01;
                end
            end
            default: begin
                if (up) begin
                    step_text = (p >= ONE_LINE_LAST) ? RST_PTR : p + 7'h01;
                end else begin
                    step_text = (p == RST_PTR) ? ONE_LINE_LAST : p - 7'h01;
                end
            end
        endcase
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        ugr_mode_t md;
        logic [PTR_W-1:0] per;
        logic [PTR_W-1:0] pos;
        logic [PTR_W-1:0] base;
        logic [PTR_W-1:0] sum;
        logic [DOT_W-1:0] dots;
        md = mode_of(st_r.mux_sel, st_r.line_cnt);
        per = period_of(md);
        pos = '0;
        base = '0;
        sum = '0;
        dots = '0;
        st_nxt = st_r;
        st_nxt.rd_valid = st_r.rd_pend;
        st_nxt.rd_pend = 1'b0;
        if (st_r.rd_pend) begin
            st_nxt.rd_data = pat.host_data;
        end
        if (cmd_valid_in) begin
            case (cmd_in)
                OP_SET_PAT_ADDR: begin
                    st_nxt.to_pattern = 1'b1;
                    st_nxt.ptr[PAT_LOAD_MSB:0] = cmd_data_in[PAT_LOAD_MSB:0];
                end
                OP_SET_TEXT_ADDR: begin
                    st_nxt.to_pattern = 1'b0;
                    st_nxt.ptr = cmd_data_in[PTR_W-1:0];
                end
                OP_WRITE, OP_READ: begin
                    st_nxt.rd_pend = (cmd_in == OP_READ) && st_r.to_pattern;
                    if (st_r.to_pattern) begin
                        st_nxt.ptr = st_r.entry_up ? st_r.ptr + 7'h01
                            : st_r.ptr - 7'h01;
                    end else begin
                        st_nxt.ptr = step_text(st_r.ptr, st_r.entry_up, md);
                    end
                end
                OP_ENTRY: begin
                    st_nxt.entry_up = cmd_data_in[1];
                end
                OP_CONFIG: begin
                    st_nxt.mux_sel = cmd_data_in[1];
                    st_nxt.line_cnt = cmd_data_in[0];
                    st_nxt.shift = '0;
                end
                OP_SHIFT: begin
                    if (cmd_data_in[0]) begin
                        st_nxt.shift = (st_r.shift == RST_PTR) ? per - 7'h01
                            : st_r.shift - 7'h01;
                    end else begin
                        st_nxt.shift = (st_r.shift >= per - 7'h01) ? RST_PTR
                            : st_r.shift + 7'h01;
                    end
                end
                default: begin
                end
            endcase
        end
        // Display pipeline stage one: address presented to the store.
        st_nxt.s1_pat = (char_code_in[CODE_BANK_MSB:CODE_BANK_LSB] == PAT_BANK);
        st_nxt.s1_cursor_line = cursor_here_in && (dot_line_in == CURSOR_LINE);
        st_nxt.s1_rom = rom_dots_in;
        // Display pipeline stage two: dots to the column drivers.
        dots = st_r.s1_pat ? pat.disp_data : st_r.s1_rom;
        if (st_r.s1_cursor_line) begin
            dots = dots | CURSOR_DOTS;
        end
        st_nxt.cols = {dots[0], dots[1], dots[2], dots[3], dots[4]};
        st_nxt.pat_sel = st_r.s1_pat;
        // Scan position to text address.
        case (md)
            MODE_TWO: begin
                pos = {2'h0, scan_col_in};
                base = scan_row_in[0] ? TWO_LINE_BASE2 : RST_PTR;
            end
            MODE_FOUR: begin
                pos = {2'h0, scan_col_in};
                base = FOUR_LINE_STEP * {5'h00, scan_row_in};
            end
            default: begin
                if (scan_col_in >= SPLIT_HALF_COLS) begin
                    pos = {2'h0, scan_col_in - SPLIT_HALF_COLS};
                    base = SPLIT_HALF_LEN;
                end else begin
                    pos = {2'h0, scan_col_in};
                    base = RST_PTR;
                end
            end
        endcase
        sum = pos + st_r.shift;
        if (sum >= per) begin
            sum = sum - per;
        end
        st_nxt.text_addr = base + sum;
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_r <= '0;
            st_r.ptr <= RST_PTR;
            st_r.entry_up <= RST_ENTRY_UP;
            st_r.mux_sel <= RST_MUX_SEL;
            st_r.line_cnt <= RST_LINE_CNT;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // Pattern store
    // ------------------------------------------------------------
    assign pat.wr_en = cmd_valid_in && (cmd_in == OP_WRITE) && st_r.to_pattern;
    assign pat.wr_addr = st_r.ptr;
    assign pat.wr_data = cmd_data_in[DOT_W-1:0];
    assign pat.host_addr = st_r.ptr;
    assign pat.disp_addr = {char_code_in[CODE_IDX_MSB:CODE_IDX_LSB], dot_line_in};

    ugr_pattern_store #(
        .DEPTH(PAT_DEPTH)
    ) u_store (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .pat(pat.store)
    );

    assign address_pointer_out = st_r.ptr;
    assign read_data_out = st_r.rd_data;
    assign read_valid_out = st_r.rd_valid;
    assign columns_out = st_r.cols;
    assign pattern_sel_out = st_r.pat_sel;
    assign text_addr_out = st_r.text_addr;
endmodule
`default_nettype wire

/* File: pkg/ugr_pkg.sv */
// Constants and types shared by the user glyph RAM addressing block.
package ugr_pkg;
    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int PTR_W = 7;
    localparam int DOT_W = 5;
    localparam int LINE_W = 3;
    localparam int CODE_W = 8;
    localparam int COL_W = 5;
    // ------------------------------------------------------------
    // Field positions and values
    // ------------------------------------------------------------
    localparam int CODE_IDX_LSB = 0;
    localparam int CODE_IDX_MSB = 3;
    localparam int CODE_BANK_LSB = 4;
    localparam int CODE_BANK_MSB = 7;
    localparam int PAT_LOAD_MSB = 5;
    localparam logic [LINE_W-1:0] CURSOR_LINE = 3'h7;
    localparam logic [DOT_W-1:0] CURSOR_DOTS = 5'h1f;
    localparam logic [3:0] PAT_BANK = 4'h0;
    // ------------------------------------------------------------
    // Text address map
    // ------------------------------------------------------------
    localparam logic [PTR_W-1:0] ONE_LINE_LAST = 7'h4f;
    localparam logic [PTR_W-1:0] TWO_LINE_LAST = 7'h27;
    localparam logic [PTR_W-1:0] TWO_LINE_BASE2 = 7'h40;
    localparam logic [PTR_W-1:0] FOUR_LINE_LAST = 7'h13;
    localparam logic [PTR_W-1:0] FOUR_LINE_STEP = 7'h20;
    localparam logic [PTR_W-1:0] SPLIT_HALF_LEN = 7'h28;
    localparam logic [COL_W-1:0] SPLIT_HALF_COLS = 5'h0c;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic RST_ENTRY_UP = 1'b1;
    localparam logic RST_MUX_SEL = 1'b0;
    localparam logic RST_LINE_CNT = 1'b0;
    localparam logic [PTR_W-1:0] RST_PTR = 7'h00;
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_NOP, OP_SET_PAT_ADDR, OP_SET_TEXT_ADDR, OP_WRITE, OP_READ,
        OP_ENTRY, OP_CONFIG, OP_SHIFT
    } ugr_op_t;
    typedef enum logic [1:0] {MODE_SPLIT, MODE_TWO, MODE_FOUR} ugr_mode_t;
endpackage

/* File: pkg/ugr_pat_if.sv */
// Connection between the addressing logic and the pattern store.
`timescale 1ns/10ps
`default_nettype none
interface ugr_pat_if;
    import ugr_pkg::*;
    logic wr_en;
    logic [PTR_W-1:0] wr_addr;
    logic [DOT_W-1:0] wr_data;
    logic [PTR_W-1:0] disp_addr;
    logic [DOT_W-1:0] disp_data;
    logic [PTR_W-1:0] host_addr;
    logic [DOT_W-1:0] host_data;
    modport ctrl (output wr_en, wr_addr, wr_data, disp_addr, host_addr,
        input disp_data, host_data);
    modport store (input wr_en, wr_addr, wr_data, disp_addr, host_addr,
        output disp_data, host_data);
endinterface
`default_nettype wire

/* File: rtl/ugr_pattern_store.sv */
// User pattern RAM with one write port and two registered read ports.
`timescale 1ns/10ps
`default_nettype none
module ugr_pattern_store
    import ugr_pkg::*;
#(
    parameter int DEPTH = 128
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Pattern port
    ugr_pat_if.store pat
);
    typedef struct packed {
        logic [DOT_W-1:0] disp;
        logic [DOT_W-1:0] host;
    } ugr_store_t;

    logic [DOT_W-1:0] mem [DEPTH];
    ugr_store_t st_r;
    ugr_store_t st_nxt;

    always_comb begin
        st_nxt.disp = mem[pat.disp_addr];
        st_nxt.host = mem[pat.host_addr];
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    always_ff @(posedge clk_in) begin
        if (pat.wr_en) begin
            mem[pat.wr_addr] <= pat.wr_data;
        end
    end

    assign pat.disp_data = st_r.disp;
    assign pat.host_data = st_r.host;
endmodule
`default_nettype wire

/* File: bench/ugr_glyph_props.sv */
// Port checker for the user glyph addressing block.
`timescale 1ns/10ps
`default_nettype none
module ugr_glyph_props
    import ugr_pkg::*;
#(
    parameter int PAT_DEPTH = 128
) (
    // Clock, reset and command port
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic cmd_valid_in,
    input wire ugr_op_t cmd_in,
    input wire logic [CODE_W-1:0] cmd_data_in,
    input wire logic [PTR_W-1:0] address_pointer_out,
    input wire logic [DOT_W-1:0] read_data_out,
    input wire logic read_valid_out,
    // Display scan port
    input wire logic [CODE_W-1:0] char_code_in,
    input wire logic [LINE_W-1:0] dot_line_in,
    input wire logic cursor_here_in,
    input wire logic [DOT_W-1:0] rom_dots_in,
    input wire logic [COL_W-1:0] scan_col_in,
    input wire logic [1:0] scan_row_in,
    input wire logic [DOT_W-1:0] columns_out,
    input wire logic pattern_sel_out,
    input wire logic [PTR_W-1:0] text_addr_out
);
    logic [DOT_W-1:0] rom_rev;
    logic cur_hit;
    logic wr_cmd;
    assign rom_rev = {<<{rom_dots_in}};
    assign cur_hit = cursor_here_in && (dot_line_in == CURSOR_LINE);
    assign wr_cmd = cmd_valid_in && (cmd_in == OP_WRITE);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    a_sel_user_bank: assert property (char_code_in[7:4] == PAT_BANK
        |-> ##2 pattern_sel_out)
        else $error("user bank code not selected");
    a_sel_rom_bank: assert property (char_code_in[7:4] != PAT_BANK
        |-> ##2 !pattern_sel_out)
        else $error("fixed bank code selected as user");
    a_rom_columns: assert property ((char_code_in[7:4] != PAT_BANK) && !cur_hit
        |-> ##2 columns_out == $past(rom_rev, 2))
        else $error("fixed dots misplaced");
    a_cursor_or: assert property (cur_hit |-> ##2 columns_out == CURSOR_DOTS)
        else $error("cursor line not merged");
    a_pat_load_low: assert property (cmd_valid_in && cmd_in == OP_SET_PAT_ADDR
        |=> address_pointer_out[5:0] == $past(cmd_data_in[5:0])
        && address_pointer_out[6] == $past(address_pointer_out[6]))
        else $error("pattern address load wrong");
    a_text_load_all: assert property (cmd_valid_in && cmd_in == OP_SET_TEXT_ADDR
        |=> address_pointer_out == $past(cmd_data_in[6:0]))
        else $error("text address load wrong");
    a_read_after_cmd: assert property (read_valid_out
        |-> $past(cmd_valid_in, 2) && $past(cmd_in, 2) == OP_READ)
        else $error("read pulse without read");
    a_step_by_one: assert property (wr_cmd && address_pointer_out inside {[7'h01:7'h12]}
        |=> address_pointer_out == $past(address_pointer_out) + 7'h01
        || address_pointer_out == $past(address_pointer_out) - 7'h01)
        else $error("pointer step not one");
    a_carry_six: assert property (wr_cmd && address_pointer_out == 7'h3f
        |=> address_pointer_out inside {7'h40, 7'h3e})
        else $error("no carry into bit six");
    a_ptr_hold: assert property (!cmd_valid_in |=> $stable(address_pointer_out))
        else $error("pointer moved without command");
    cover property (read_valid_out);
    cover property (cur_hit ##2 pattern_sel_out);
    cover property (cmd_valid_in && cmd_in == OP_SHIFT);
endmodule
bind ugr_glyph_addr ugr_glyph_props #(.PAT_DEPTH(PAT_DEPTH)) u_props (.clk_in, .rst_n_in,
    .cmd_valid_in, .cmd_in, .cmd_data_in, .address_pointer_out, .read_data_out, .read_valid_out,
    .char_code_in, .dot_line_in, .cursor_here_in, .rom_dots_in, .scan_col_in, .scan_row_in,
    .columns_out, .pattern_sel_out, .text_addr_out);
`default_nettype wire

/* File: bench/ugr_disp_model.sv */
// Behavioural row and column driver side: scan position and fixed glyph dots.
`timescale 1ns/10ps
`default_nettype none
module ugr_disp_model
    import ugr_pkg::*;
(
    // Requested scan position
    input wire logic [CODE_W-1:0] code_req_in,
    input wire logic [LINE_W-1:0] line_req_in,
    input wire logic cursor_req_in,
    input wire logic [COL_W-1:0] col_req_in,
    input wire logic [1:0] row_req_in,
    // Scan drive towards the block
    output logic [CODE_W-1:0] char_code_out,
    output logic [LINE_W-1:0] dot_line_out,
    output logic cursor_here_out,
    output logic [DOT_W-1:0] rom_dots_out,
    output logic [COL_W-1:0] scan_col_out,
    output logic [1:0] scan_row_out
);
    assign char_code_out = code_req_in;
    assign dot_line_out = line_req_in;
    assign cursor_here_out = cursor_req_in;
    assign scan_col_out = col_req_in;
    assign scan_row_out = row_req_in;
    // Stand-in glyph table, bit 4 is the left column.
    assign rom_dots_out = code_req_in[4:0] ^ {line_req_in, line_req_in[1:0]};
endmodule
`default_nettype wire

/* File: bench/testbench.sv */
// Self-checking bench for the user glyph addressing block.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin bad_count++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); end end
module testbench;
    import ugr_pkg::*;
    logic clk_in, rst_n_in, cmd_valid_in, read_valid_out, pattern_sel_out, cursor_here_in, cur_req;
    ugr_op_t cmd_in;
    logic [CODE_W-1:0] cmd_data_in, char_code_in, code_req;
    logic [LINE_W-1:0] dot_line_in, line_req;
    logic [COL_W-1:0] scan_col_in, col_req;
    logic [1:0] scan_row_in, row_req;
    logic [DOT_W-1:0] read_data_out, columns_out, rom_dots_in, exp_d;
    logic [PTR_W-1:0] address_pointer_out, text_addr_out, exp_a;
    logic [DOT_W-1:0] mem [128];
    logic [31:0] r;
    int bad_count, cmp_count, seed, k, s;
    initial begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end
    ugr_disp_model u_disp (.code_req_in(code_req), .line_req_in(line_req),
        .cursor_req_in(cur_req), .col_req_in(col_req), .row_req_in(row_req),
        .char_code_out(char_code_in),
        .dot_line_out(dot_line_in), .cursor_here_out(cursor_here_in),
        .rom_dots_out(rom_dots_in), .scan_col_out(scan_col_in), .scan_row_out(scan_row_in));
    ugr_glyph_addr #(.PAT_DEPTH(128)) dut (.clk_in, .rst_n_in, .cmd_valid_in, .cmd_in,
        .cmd_data_in, .address_pointer_out, .read_data_out, .read_valid_out, .char_code_in,
        .dot_line_in, .cursor_here_in, .rom_dots_in, .scan_col_in, .scan_row_in,
        .columns_out, .pattern_sel_out, .text_addr_out);
    function automatic logic [DOT_W-1:0] flip(input logic [DOT_W-1:0] d);
        return {d[0], d[1], d[2], d[3], d[4]};
    endfunction
    function automatic logic [DOT_W-1:0] rom_f(input logic [7:0] c, input logic [2:0] l);
        return c[4:0] ^ {l, l[1:0]};
    endfunction
    function automatic logic [PTR_W-1:0] split_addr(input int col, input int sh);
        if (col < 12) begin
            return 7'((col + sh) % 40);
        end
        return 7'h28 + 7'((col - 12 + sh) % 40);
    endfunction
    function automatic logic [PTR_W-1:0] grid_addr(input logic four, input int col, input int row,
        input int sh);
        if (four) begin
            return 7'(row * 32 + (col + sh) % 20);
        end
        return 7'((row % 2) * 64 + (col + sh) % 40);
    endfunction
    task automatic print_verdict();
        if (bad_count == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic cmd(input ugr_op_t op, input logic [7:0] d);
        @(negedge clk_in);
        cmd_valid_in = 1'b1;
        cmd_in = op;
        cmd_data_in = d;
        @(negedge clk_in);
        cmd_valid_in = 1'b0;
        cmd_in = OP_NOP;
    endtask
    task automatic rd_chk(input logic [PTR_W-1:0] a);
        int n;
        cmd(OP_READ, 8'h00);
        n = 0;
        while (read_valid_out !== 1'b1 && n < 4) begin
            @(negedge clk_in);
            n++;
        end
        if (n == 4) begin
            bad_count++;
            print_verdict();
        end
        `CHK("read data", mem[a], read_data_out)
    endtask
    initial begin
        seed = 32'h248e;
        rst_n_in = 1'b0;
        cmd_valid_in = 1'b0;
        cmd_in = OP_NOP;
        cmd_data_in = 8'h00;
        code_req = 8'h00;
        line_req = 3'h0;
        cur_req = 1'b0;
        col_req = 5'h00;
        row_req = 2'h0;
        bad_count = 0;
        cmp_count = 0;
        repeat (16) @(negedge clk_in);
        rst_n_in = 1'b1;
        `CHK("reset pointer", RST_PTR, address_pointer_out)
        cmd(OP_SET_PAT_ADDR, 8'h00);
        for (k = 0; k < 128; k++) begin
            r = $random(seed);
            cmd(OP_WRITE, {3'h0, r[4:0]});
            mem[k] = r[4:0];
            `CHK("pointer", 7'(k + 1), address_pointer_out)
        end
        cmd(OP_SET_TEXT_ADDR, 8'h40);
        cmd(OP_SET_PAT_ADDR, 8'hc5);
        `CHK("pointer", 7'h45, address_pointer_out)
        rd_chk(7'h45);
        `CHK("pointer", 7'h46, address_pointer_out)
        cmd(OP_ENTRY, 8'h00);
        cmd(OP_WRITE, 8'h0a);
        mem[7'h46] = 5'h0a;
        `CHK("pointer", 7'h45, address_pointer_out)
        cmd(OP_SET_PAT_ADDR, 8'h06);
        rd_chk(7'h46);
        cmd(OP_ENTRY, 8'h02);
        cmd(OP_SET_TEXT_ADDR, 8'h4f);
        cmd(OP_WRITE, 8'h41);
        `CHK("pointer", 7'h00, address_pointer_out)
        cmd(OP_ENTRY, 8'h00);
        cmd(OP_WRITE, 8'h41);
        `CHK("pointer", 7'h4f, address_pointer_out)
        cmd(OP_CONFIG, 8'h00);
        for (s = 0; s < 3; s++) begin
            for (k = 0; k < 24; k++) begin
                @(negedge clk_in);
                col_req = k[4:0];
                @(negedge clk_in);
                `CHK("text address", split_addr(k, (s == 2) ? 39 : s), text_addr_out)
            end
            if (s == 0) begin
                cmd(OP_SHIFT, 8'h00);
            end else begin
                repeat (2) cmd(OP_SHIFT, 8'h01);
            end
        end
        for (s = 0; s < 4; s++) begin
            cmd(OP_CONFIG, (s < 2) ? 8'h01 : 8'h03);
            if (s == 1 || s == 3) begin
                cmd(OP_SHIFT, 8'h01);
            end
            for (k = 0; k < 16; k++) begin
                r = $random(seed);
                @(negedge clk_in);
                col_req = (s < 2) ? r[4:0] : 5'(r[4:0] % 5'h14);
                row_req = r[6:5];
                @(negedge clk_in);
                exp_a = grid_addr(s >= 2, col_req, row_req, (s % 2) * ((s < 2) ? 39 : 19));
                `CHK("text address", exp_a, text_addr_out)
            end
        end
        cmd(OP_CONFIG, 8'h01);
        cmd(OP_SET_TEXT_ADDR, 8'h40);
        cmd(OP_WRITE, 8'h41);
        `CHK("pointer", 7'h27, address_pointer_out)
        cmd(OP_SET_TEXT_ADDR, 8'h00);
        cmd(OP_WRITE, 8'h41);
        `CHK("pointer", 7'h67, address_pointer_out)
        cmd(OP_CONFIG, 8'h03);
        cmd(OP_SET_TEXT_ADDR, 8'h60);
        cmd(OP_WRITE, 8'h41);
        `CHK("pointer", 7'h53, address_pointer_out)
        for (k = 0; k < 300; k++) begin
            r = $random(seed);
            @(negedge clk_in);
            code_req = r[31] ? {4'h0, r[3:0]} : r[11:4];
            line_req = (k < 16) ? 3'h7 : r[14:12];
            cur_req = r[15];
            repeat (2) @(negedge clk_in);
            exp_d = rom_f(code_req, line_req);
            if (code_req[7:4] == PAT_BANK) begin
                exp_d = mem[{code_req[3:0], line_req}];
            end
            if (line_req == CURSOR_LINE && cur_req) begin
                exp_d = exp_d | CURSOR_DOTS;
            end
            `CHK("columns", flip(exp_d), columns_out)
            `CHK("pattern select", code_req[7:4] == PAT_BANK, pattern_sel_out)
        end
        print_verdict();
    end
endmodule
`default_nettype wire
